// >>> scr_defs.vh
// Constants for the system control coprocessor register bank.
// Assumes inclusion by bare name from every scr_ design file.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// ---------------------------------------------------------------
// Coprocessor register numbers
// ---------------------------------------------------------------
`define SCR_REG_INFO    4'h0
`define SCR_REG_CTRL    4'h1
`define SCR_REG_TBASE   4'h2
`define SCR_REG_DOMAIN  4'h3
`define SCR_REG_RSVD4   4'h4
`define SCR_REG_FSTAT   4'h5
`define SCR_REG_FADDR   4'h6

// Secondary operation selector for register zero
`define SCR_OPC2_ID     3'h0
`define SCR_OPC2_GEOM   3'h1

// ---------------------------------------------------------------
// Control word bit positions
// ---------------------------------------------------------------
`define SCR_CTRL_MMU    0
`define SCR_CTRL_ALIGN  1
`define SCR_CTRL_DCACHE 2
`define SCR_CTRL_BIGEND 7
`define SCR_CTRL_SYSP   8
`define SCR_CTRL_ROMP   9
`define SCR_CTRL_ICACHE 12
`define SCR_CTRL_VHIGH  13
`define SCR_CTRL_RROBIN 14
`define SCR_CTRL_NFAST  30
`define SCR_CTRL_ASYNC  31
// Writable bits, constant ones, reset value
`define SCR_CTRL_WMASK  32'hC000_7387
`define SCR_CTRL_ONES   32'h0200_0078
`define SCR_CTRL_RESET  32'h0200_0078
// Reserved clocking code in [31:30]
`define SCR_CLK_RSVD    2'b10

// ---------------------------------------------------------------
// Field layouts and reset values
// ---------------------------------------------------------------
`define SCR_TBASE_MASK  32'hFFFF_C000
`define SCR_TBASE_RESET 32'h0000_0000
`define SCR_DOM_RESET   32'h0000_0000
`define SCR_FSTAT_RESET 8'h00
`define SCR_FADDR_RESET 32'h0000_0000
`define SCR_VEC_LOW     32'h0000_0000
`define SCR_VEC_HIGH    32'hFFFF_0000
// Domain field codes
`define SCR_DOM_NOACC   2'b00
`define SCR_DOM_CLIENT  2'b01
`define SCR_DOM_MANAGER 2'b11
// Fixed parts of the information words
`define SCR_ID_ARCH     4'h2
`define SCR_ID_SPECREV  4'h1
`define SCR_GEOM_SPLIT  1'b1

`endif

// >>> scr_domain_decode.v
// Decodes the sixteen domain access fields for one queried domain.
// Assumes the query comes from MMU logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.vh"

module scr_domain_decode (
  input  wire        clk,           // Core clock
  input  wire        reset_n,       // Async reset, active low
  input  wire        ce,            // Clock enable
  input  wire [31:0] domain_fields, // Sixteen packed 2-bit fields
  input  wire [3:0]  query_domain,  // Domain of current access
  output reg         dom_fault_q,   // No access: domain fault
  output reg         dom_check_q,   // Client: check permissions
  output reg         dom_manager_q  // Manager: no checks
);

  wire [15:0] no_acc;
  wire [15:0] client;
  wire [15:0] manager;

  // ---------------------------------------------------------------
  // Per-domain decode; reserved code 10 yields no flag at all
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : dom
      // Domain g sits in bits [2g+1:2g]
      assign no_acc[g]  = domain_fields[2*g+1:2*g] == `SCR_DOM_NOACC;
      assign client[g]  = domain_fields[2*g+1:2*g] == `SCR_DOM_CLIENT;
      assign manager[g] = domain_fields[2*g+1:2*g] == `SCR_DOM_MANAGER;
    end
  endgenerate

  // Registered answer for the queried domain
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dom_fault_q   <= 1'b0;
      dom_check_q   <= 1'b0;
      dom_manager_q <= 1'b0;
    end else if (ce) begin
      dom_fault_q   <= no_acc[query_domain];
      dom_check_q   <= client[query_domain];
      dom_manager_q <= manager[query_domain];
    end
  end

endmodule
`default_nettype wire

// >>> scr_fault_capture.v
// Fault status and fault address storage.
// Assumes abort strobes are one-cycle pulses from logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.vh"

module scr_fault_capture (
  input  wire        clk,           // Core clock
  input  wire        reset_n,       // Async reset, active low
  input  wire        ce,            // Clock enable
  input  wire        dabort,        // Data abort pulse
  input  wire [3:0]  dabort_type,   // Fault type code
  input  wire [3:0]  dabort_domain, // Domain accessed
  input  wire [31:0] dabort_mva,    // Faulting modified address
  input  wire        pabort,        // Prefetch abort pulse
  input  wire        wr_status,     // Software write to status
  input  wire        wr_address,    // Software write to address
  input  wire [31:0] wdata,         // Software write data
  output reg  [7:0]  fstat_q,       // Domain[7:4], type[3:0]
  output reg  [31:0] faddr_q        // Fault address
);

  // ---------------------------------------------------------------
  // Capture; a data abort in the same cycle as a write wins, so a
  // real fault is never lost under a debugger restore
  // ---------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstat_q <= `SCR_FSTAT_RESET;
      faddr_q <= `SCR_FADDR_RESET;
    end else if (ce) begin
      // Prefetch aborts are deliberately not looked at
      if (dabort) begin
        fstat_q <= {dabort_domain, dabort_type};
        faddr_q <= dabort_mva;
      end else begin
        if (wr_status)
          fstat_q <= wdata[7:0];
        if (wr_address)
          faddr_q <= wdata;
      end
    end
  end

  // pabort is taken only to document that it has no effect
  wire unused_pabort = pabort;

endmodule
`default_nettype wire

// >>> scr_regs.v
// System control coprocessor register bank for a core with MMU
// and split caches, reached by coprocessor register transfers.
// Assumes transfers and abort strobes come from logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.vh"

module scr_regs #(
  parameter [7:0]  ID_IMPL    = 8'h5A,   // Arbitrary implementor code
  parameter [11:0] ID_PART    = 12'h3C5, // Arbitrary part number
  parameter [3:0]  ID_LAYOUT  = 4'h0,    // Arbitrary layout revision
  parameter [11:0] GEOM_INSTR_CACHE_GEOMETRY = 12'h000, // Instruction cache geometry
  parameter [11:0] GEOM_DATA_CACHE_GEOMETRY = 12'h000, // Data cache geometry
  parameter [3:0]  GEOM_CTYPE = 4'h0     // Cache type code
) (
  input  wire        clk,            // Core clock, 10 MHz
  input  wire        reset_n,        // Async reset, active low
  input  wire        ce,             // Clock enable, freezes all
  input  wire        cp_valid,       // Register transfer request
  input  wire        cp_write,       // 1 core-to-coproc, 0 read
  input  wire [3:0]  cp_reg,         // Coprocessor register number
  input  wire [2:0]  cp_opc2,        // Secondary operation selector
  input  wire [31:0] cp_wdata,       // Write data from core
  output reg  [31:0] cp_rdata_q,     // Read data to core
  output reg         cp_rvalid_q,    // Read data valid pulse
  input  wire        dabort,         // Data abort pulse
  input  wire [3:0]  dabort_type,    // Data fault type
  input  wire [3:0]  dabort_domain,  // Data fault domain
  input  wire [31:0] dabort_mva,     // Data fault address
  input  wire        pabort,         // Prefetch abort pulse
  input  wire [3:0]  query_domain,   // Domain of MMU access
  output wire        dom_fault,      // Queried domain: no access
  output wire        dom_check,      // Queried domain: client
  output wire        dom_manager,    // Queried domain: manager
  output wire        mmu_enable,     // MMU on
  output wire        align_check,    // Alignment faults on
  output wire        dcache_enable,  // Data cache on
  output wire        icache_enable,  // Instruction cache on
  output wire        big_endian,     // Big endian mode
  output wire        sys_protect,    // System protection modifier
  output wire        rom_protect,    // ROM protection modifier
  output wire        roundrobin_replace_select, // Round-robin victims
  output wire        not_fastbus_select,        // Clock mode low bit
  output wire        async_clock_select,        // Clock mode high bit
  output reg  [31:0] vector_base_q,  // Exception vector base
  output wire [17:0] translation_base // Table pointer [31:14]
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  reg  [31:0] tbase_q;
  reg  [31:0] domain_fields_q;
  reg  [31:0] rdata_d;
  wire [7:0]  fstat;
  wire [31:0] faddr;

  // ---------------------------------------------------------------
  // Transfer decode
  // ---------------------------------------------------------------
  wire wr_any  = cp_valid & cp_write;
  wire rd_any  = cp_valid & ~cp_write;
  wire wr_ctrl = wr_any & (cp_reg == `SCR_REG_CTRL);
  wire wr_tb   = wr_any & (cp_reg == `SCR_REG_TBASE);
  wire wr_dom  = wr_any & (cp_reg == `SCR_REG_DOMAIN);
  wire wr_fs   = wr_any & (cp_reg == `SCR_REG_FSTAT);
  wire wr_fa   = wr_any & (cp_reg == `SCR_REG_FADDR);

  // Fixed information words
  wire [31:0] id_word = {ID_IMPL, `SCR_ID_SPECREV, `SCR_ID_ARCH,
                         ID_PART, ID_LAYOUT};
  // Top three geometry bits read zero
  wire [31:0] geom_word = {3'b000, GEOM_CTYPE, `SCR_GEOM_SPLIT,
                           GEOM_DATA_CACHE_GEOMETRY, GEOM_INSTR_CACHE_GEOMETRY};

  // ---------------------------------------------------------------
  // Control word next value
  // ---------------------------------------------------------------
  // Writable bits from software, fixed bits forced. A write of
  // the reserved clock code keeps the old clock mode, since a
  // half-switched clock would hang the core.
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = (cp_wdata & `SCR_CTRL_WMASK) | `SCR_CTRL_ONES;
      if (cp_wdata[31:30] == `SCR_CLK_RSVD)
        ctrl_d[31:30] = ctrl_q[31:30];
    end
  end

  // Control and vector base registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q        <= `SCR_CTRL_RESET;
      vector_base_q <= `SCR_VEC_LOW;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      // Vector base follows the bit in the same cycle
      if (ctrl_d[`SCR_CTRL_VHIGH])
        vector_base_q <= `SCR_VEC_HIGH;
      else
        vector_base_q <= `SCR_VEC_LOW;
    end
  end

  // Control outputs straight from the control flops
  assign mmu_enable    = ctrl_q[`SCR_CTRL_MMU];
  assign align_check   = ctrl_q[`SCR_CTRL_ALIGN];
  assign dcache_enable = ctrl_q[`SCR_CTRL_DCACHE];
  assign icache_enable = ctrl_q[`SCR_CTRL_ICACHE];
  assign big_endian    = ctrl_q[`SCR_CTRL_BIGEND];
  assign sys_protect   = ctrl_q[`SCR_CTRL_SYSP];
  assign rom_protect   = ctrl_q[`SCR_CTRL_ROMP];
  assign roundrobin_replace_select = ctrl_q[`SCR_CTRL_RROBIN];
  assign not_fastbus_select = ctrl_q[`SCR_CTRL_NFAST];
  assign async_clock_select = ctrl_q[`SCR_CTRL_ASYNC];

  // ---------------------------------------------------------------
  // Translation base and domain access word
  // ---------------------------------------------------------------
  // Only pointer bits are stored; the rest read zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tbase_q         <= `SCR_TBASE_RESET;
      domain_fields_q <= `SCR_DOM_RESET;
    end else if (ce) begin
      if (wr_tb)
        tbase_q <= cp_wdata & `SCR_TBASE_MASK;
      if (wr_dom)
        domain_fields_q <= cp_wdata;
    end
  end

  assign translation_base = tbase_q[31:14];

  // Domain decode for the MMU's current access
  scr_domain_decode u_dom (
    .clk           (clk),
    .reset_n       (reset_n),
    .ce            (ce),
    .domain_fields (domain_fields_q),
    .query_domain  (query_domain),
    .dom_fault_q   (dom_fault),
    .dom_check_q   (dom_check),
    .dom_manager_q (dom_manager)
  );

  // ---------------------------------------------------------------
  // Fault registers
  // ---------------------------------------------------------------
  scr_fault_capture u_fault (
    .clk           (clk),
    .reset_n       (reset_n),
    .ce            (ce),
    .dabort        (dabort),
    .dabort_type   (dabort_type),
    .dabort_domain (dabort_domain),
    .dabort_mva    (dabort_mva),
    .pabort        (pabort),
    .wr_status     (wr_fs),
    .wr_address    (wr_fa),
    .wdata         (cp_wdata),
    .fstat_q       (fstat),
    .faddr_q       (faddr)
  );

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Register 4 and unknown numbers read zero; software is not
  // meant to go there, so any stable value will do.
  always @* begin
    rdata_d = 32'h0000_0000;
    case (cp_reg)
      `SCR_REG_INFO: begin
        if (cp_opc2 == `SCR_OPC2_GEOM)
          rdata_d = geom_word;
        else if (cp_opc2 == `SCR_OPC2_ID)
          rdata_d = id_word;
        else
          rdata_d = id_word;
      end
      `SCR_REG_CTRL:   rdata_d = ctrl_q;
      `SCR_REG_TBASE:  rdata_d = tbase_q;
      `SCR_REG_DOMAIN: rdata_d = domain_fields_q;
      `SCR_REG_RSVD4:  rdata_d = 32'h0000_0000;
      `SCR_REG_FSTAT:  rdata_d = {24'h00_0000, fstat};
      `SCR_REG_FADDR:  rdata_d = faddr;
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // Registered read answer, one cycle after the request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cp_rdata_q  <= 32'h0000_0000;
      cp_rvalid_q <= 1'b0;
    end else if (ce) begin
      cp_rvalid_q <= rd_any;
      if (rd_any)
        cp_rdata_q <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// >>> scr_regs_properties.sv
// Checker for the system control register bank ports.
// Assumes one clock, async active-low reset, bound by name.
`timescale 1ns/100ps
`default_nettype none

module scr_regs_properties (
  input wire logic        clk,                       // Core clock
  input wire logic        reset_n,                   // Async reset, active low
  input wire logic        ce,                        // Clock enable
  input wire logic        cp_valid,                  // Transfer request
  input wire logic        cp_write,                  // Transfer direction
  input wire logic [3:0]  cp_reg,                    // Register number
  input wire logic [2:0]  cp_opc2,                   // Selector
  input wire logic [31:0] cp_wdata,                  // Write data
  input wire logic [31:0] cp_rdata_q,                // Read data
  input wire logic [31:0] vector_base_q,             // Vector base
  input wire logic        cp_rvalid_q,               // Read answer
  input wire logic [3:0]  query_domain,              // Queried domain
  input wire logic        dom_fault,                 // Domain: no access
  input wire logic        dom_check,                 // Domain: client
  input wire logic        dom_manager,               // Domain: manager
  input wire logic        mmu_enable,                // MMU on
  input wire logic        align_check,               // Alignment faults on
  input wire logic        dcache_enable,             // Data cache on
  input wire logic        icache_enable,             // Instruction cache on
  input wire logic        big_endian,                // Big endian
  input wire logic        sys_protect,               // System protection
  input wire logic        rom_protect,               // ROM protection
  input wire logic        roundrobin_replace_select, // Round-robin victims
  input wire logic        not_fastbus_select,        // Clock mode low bit
  input wire logic        async_clock_select,        // Clock mode high bit
  input wire logic [17:0] translation_base           // Table pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // Decoded transfers
  // ---------------------------------------------------------------
  wire rd  = ce && cp_valid && !cp_write;
  wire wr1 = ce && cp_valid && cp_write && cp_reg == 4'h1;
  wire wr2 = ce && cp_valid && cp_write && cp_reg == 4'h2;
  // Shadow of the domain word, so the decode is checked per field
  logic [31:0] dom_shadow;
  wire  [1:0]  dom_code = dom_shadow[2*query_domain +: 2];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) dom_shadow <= 32'h0000_0000;
    else if (ce && cp_valid && cp_write && cp_reg == 4'h3) dom_shadow <= cp_wdata;
  end
  a_read_answer: assert property (rd |=> cp_rvalid_q) else $error("read unanswered");
  // A frozen clock enable holds the answer flop, so only a live edge counts
  a_answer_cause: assert property (cp_rvalid_q && $past(ce) |-> $past(rd)) else
    $error("stray answer");
  a_geom_split: assert property (rd && cp_reg == 4'h0 && cp_opc2 == 3'h1 |=>
    cp_rdata_q[24] && cp_rdata_q[31:29] == 3'h0) else $error("geometry word bad");
  a_id_arch: assert property (rd && cp_reg == 4'h0 && cp_opc2 == 3'h0 |=>
    cp_rdata_q[19:16] == 4'h2) else $error("id word bad");
  a_enable_bits: assert property (wr1 |=> {mmu_enable, align_check, dcache_enable,
    icache_enable, big_endian} == $past({cp_wdata[0], cp_wdata[1], cp_wdata[2],
    cp_wdata[12], cp_wdata[7]})) else $error("enable bits bad");
  a_protect_bits: assert property (wr1 |=> {sys_protect, rom_protect,
    roundrobin_replace_select} == $past({cp_wdata[8], cp_wdata[9], cp_wdata[14]}))
    else $error("protect bits bad");
  a_vector_base: assert property (wr1 |=> vector_base_q ==
    ($past(cp_wdata[13]) ? 32'hFFFF_0000 : 32'h0000_0000)) else $error("vector base bad");
  a_clock_mode: assert property (wr1 |=> {async_clock_select, not_fastbus_select} ==
    ($past(cp_wdata[31:30]) == 2'b10 ? $past({async_clock_select, not_fastbus_select})
    : $past(cp_wdata[31:30]))) else $error("clock mode bad");
  a_tbase_load: assert property (wr2 |=> translation_base == $past(cp_wdata[31:14]))
    else $error("table base bad");
  a_domain_onehot: assert property ($onehot0({dom_fault, dom_check, dom_manager}))
    else $error("domain decode bad");
  a_domain_decode: assert property (ce |=> {dom_fault, dom_check, dom_manager} ==
    {$past(dom_code) == 2'b00, $past(dom_code) == 2'b01, $past(dom_code) == 2'b11})
    else $error("domain answer bad");
endmodule

bind scr_regs scr_regs_properties i_scr_regs_properties (.clk(clk), .reset_n(reset_n),
  .ce(ce), .cp_valid(cp_valid), .cp_write(cp_write), .cp_reg(cp_reg), .cp_opc2(cp_opc2),
  .cp_wdata(cp_wdata), .cp_rdata_q(cp_rdata_q), .vector_base_q(vector_base_q),
  .cp_rvalid_q(cp_rvalid_q), .query_domain(query_domain), .dom_fault(dom_fault),
  .dom_check(dom_check),
  .dom_manager(dom_manager), .mmu_enable(mmu_enable), .align_check(align_check),
  .dcache_enable(dcache_enable), .icache_enable(icache_enable), .big_endian(big_endian),
  .sys_protect(sys_protect), .rom_protect(rom_protect),
  .roundrobin_replace_select(roundrobin_replace_select),
  .not_fastbus_select(not_fastbus_select), .async_clock_select(async_clock_select),
  .translation_base(translation_base));
`default_nettype wire

// >>> scr_core_model.sv
// Core model issuing coprocessor register transfers.
// Assumes a registered read answer one cycle after the request.
`timescale 1ns/100ps
`default_nettype none

module scr_core_model (
  input  wire logic        clk,         // Core clock
  input  wire logic [31:0] cp_rdata_q,  // Read data
  input  wire logic        cp_rvalid_q, // Read answer pulse
  output logic             cp_valid,    // Request
  output logic             cp_write,    // Direction
  output logic [3:0]       cp_reg,      // Register number
  output logic [2:0]       cp_opc2,     // Selector
  output logic [31:0]      cp_wdata     // Write data
);
  // ---------------------------------------------------------------
  // One transfer; released data and selector lines show inverted junk, not old data
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [3:0] r, input logic [2:0] op,
                      input logic [31:0] w, output logic [31:0] rd);
    rd = 'x;
    if (r == 4'h4) return; // Register four is never touched
    @(posedge clk);
    #1;
    cp_valid = 1'b1;
    cp_write = wr;
    cp_reg = r;
    cp_opc2 = op;
    cp_wdata = w;
    @(posedge clk);
    #1;
    if (!wr && cp_rvalid_q === 1'b1) rd = cp_rdata_q;
    cp_valid = 1'b0;
    cp_wdata = ~cp_wdata;
    cp_opc2 = ~cp_opc2;
  endtask
  // Idle bus at time zero
  initial begin
    cp_valid = 1'b0;
    cp_write = 1'b0;
    cp_reg = 4'h0;
    cp_opc2 = 3'h0;
    cp_wdata = 32'h0000_0000;
  end
endmodule
`default_nettype wire

// >>> scr_regs_tb.sv
// Self-checking bench for the system control register bank.
// Assumes the core model drives transfers; aborts come from here.
`timescale 1ns/100ps
`default_nettype none

module scr_regs_tb;
  typedef struct {logic [3:0] r; logic [31:0] w; logic [31:0] e;} scr_row_t;
  logic clk = 0, reset_n = 0, ce = 1, dabort = 0, pabort = 0;
  logic [3:0] dabort_type = 4'h0, dabort_domain = 4'h0, query_domain = 4'h0;
  logic [31:0] dabort_mva = 32'h0000_0000, rd, dw;
  wire cp_valid, cp_write, cp_rvalid_q, dom_fault, dom_check, dom_manager;
  wire [3:0] cp_reg;
  wire [2:0] cp_opc2;
  wire [31:0] cp_wdata, cp_rdata_q, vector_base_q;
  wire [17:0] translation_base;
  int n_mismatch = 0, check_count = 0, cycles = 0, n;
  // Only defined bits are written
  scr_row_t rows [0:7] = '{'{4'h1, 32'hC000_7387, 32'hC200_73FF},
    '{4'h1, 32'h4000_2001, 32'h4200_2079}, '{4'h1, 32'h0000_0000, 32'h0200_0078},
    '{4'h2, 32'hFFFF_C000, 32'hFFFF_C000}, '{4'h2, 32'h1234_4000, 32'h1234_4000},
    '{4'h3, 32'hE4E4_1B1B, 32'hE4E4_1B1B}, '{4'h5, 32'h0000_00A5, 32'h0000_00A5},
    '{4'h6, 32'hDEAD_BEEF, 32'hDEAD_BEEF}};

  // Odd geometry values expose misplaced fields
  scr_regs #(.GEOM_INSTR_CACHE_GEOMETRY(12'hABC), .GEOM_DATA_CACHE_GEOMETRY(12'h123), .GEOM_CTYPE(4'h6)) i_scr_regs (
    .clk(clk), .reset_n(reset_n), .ce(ce), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_reg(cp_reg), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata), .cp_rdata_q(cp_rdata_q),
    .cp_rvalid_q(cp_rvalid_q), .dabort(dabort), .dabort_type(dabort_type),
    .dabort_domain(dabort_domain), .dabort_mva(dabort_mva), .pabort(pabort),
    .query_domain(query_domain), .dom_fault(dom_fault), .dom_check(dom_check),
    .dom_manager(dom_manager), .mmu_enable(), .align_check(), .dcache_enable(),
    .icache_enable(), .big_endian(), .sys_protect(), .rom_protect(),
    .roundrobin_replace_select(), .not_fastbus_select(), .async_clock_select(),
    .vector_base_q(vector_base_q), .translation_base(translation_base));
  scr_core_model i_scr_core_model (.clk(clk), .cp_rdata_q(cp_rdata_q),
    .cp_rvalid_q(cp_rvalid_q), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_reg(cp_reg), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata));

  // ---------------------------------------------------------------
  // Clock, hang guard, checking and verdict
  // ---------------------------------------------------------------
  always #50 clk = ~clk;
  // Whole run needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic pulse(input logic pf, input logic [3:0] t, input logic [3:0] d,
                       input logic [31:0] a);
    @(posedge clk);
    #1;
    {pabort, dabort, dabort_type, dabort_domain, dabort_mva} = {pf, !pf, t, d, a};
    @(posedge clk);
    #1;
    {pabort, dabort, dabort_mva} = {2'b00, ~a};
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1;
    for (n = 1; n < 7; n++) begin
      if (n == 4) continue;
      i_scr_core_model.xfer(0, n[3:0], 3'h0, 32'h0000_0000, rd);
      check("reset value", rd, n == 1 ? 32'h0200_0078 : 32'h0000_0000);
    end
    foreach (rows[i]) begin
      i_scr_core_model.xfer(1, rows[i].r, 3'h0, rows[i].w, rd);
      i_scr_core_model.xfer(0, rows[i].r, 3'h0, 32'h0000_0000, rd);
      check("readback", rd, rows[i].e);
    end
    // Identification and geometry words; implementor code is arbitrary
    i_scr_core_model.xfer(0, 4'h0, 3'h0, 32'h0000_0000, rd);
    check("id word", rd, 32'h5A12_3C50);
    i_scr_core_model.xfer(0, 4'h0, 3'h1, 32'h0000_0000, rd);
    check("geometry", rd, 32'h0D12_3ABC);
    // Reserved clocking code keeps the previous mode
    i_scr_core_model.xfer(1, 4'h1, 3'h0, 32'h4000_0000, rd);
    i_scr_core_model.xfer(1, 4'h1, 3'h0, 32'h8000_2001, rd);
    check("vector base", vector_base_q, 32'hFFFF_0000);
    i_scr_core_model.xfer(0, 4'h1, 3'h0, 32'h0000_0000, rd);
    check("clock mode", rd, 32'h4200_2079);
    // Data abort captured, prefetch abort ignored
    pulse(0, 4'h5, 4'hC, 32'h1234_5678);
    pulse(1, 4'hA, 4'h3, 32'h9ABC_DEF0);
    i_scr_core_model.xfer(0, 4'h5, 3'h0, 32'h0000_0000, rd);
    check("fault status", rd, 32'h0000_00C5);
    i_scr_core_model.xfer(0, 4'h6, 3'h0, 32'h0000_0000, rd);
    check("fault address", rd, 32'h1234_5678);
    // Abort and software write in one cycle: the abort wins
    fork
      pulse(0, 4'h1, 4'h2, 32'h0BAD_F00D);
      i_scr_core_model.xfer(1, 4'h6, 3'h0, 32'h1111_1111, rd);
    join
    i_scr_core_model.xfer(0, 4'h6, 3'h0, 32'h0000_0000, rd);
    check("abort wins", rd, 32'h0BAD_F00D);
    i_scr_core_model.xfer(0, 4'h5, 3'h0, 32'h0000_0000, rd);
    check("abort status", rd, 32'h0000_0021);
    // Every domain field decoded; the word holds all four codes
    dw = rows[5].w;
    for (n = 0; n < 16; n++) begin
      query_domain = n[3:0];
      @(posedge clk);
      #1;
      check("domain", {29'h0, dom_fault, dom_check, dom_manager}, {29'h0,
        dw[2*n+:2] == 2'b00, dw[2*n+:2] == 2'b01, dw[2*n+:2] == 2'b11});
    end
    // Clock enable low: a write must not land
    ce = 0;
    i_scr_core_model.xfer(1, 4'h2, 3'h0, 32'hABCD_C000, rd);
    ce = 1;
    check("table base", {14'h0, translation_base}, {14'h0, rows[4].w[31:14]});
    // Mid-run reset brings back the reset values
    reset_n = 0;
    @(posedge clk);
    #1 reset_n = 1;
    check("reset vector", vector_base_q, 32'h0000_0000);
    check("reset table", {14'h0, translation_base}, 32'h0000_0000);
    i_scr_core_model.xfer(0, 4'h1, 3'h0, 32'h0000_0000, rd);
    check("reset control", rd, 32'h0200_0078);
    give_verdict();
  end
endmodule
`default_nettype wire
